// ### ashp_map.svh
// Purpose: Offsets, field positions, reset values and counts of the serial host port.
// Assumes: Included by its bare name from the design file.
// Notes: Definitions only.
`ifndef ASHP_MAP_SVH
`define ASHP_MAP_SVH
// APB register offsets, byte addresses.
`define ASHP_OFS_CTRL 12'h000
`define ASHP_OFS_CONFIG 12'h004
`define ASHP_OFS_STATUS 12'h008
`define ASHP_OFS_RESULT 12'h00C
// Control register fields.
`define ASHP_CTRL_FOUR_CHAN 0
`define ASHP_CTRL_RESET 1'h0
// Configuration word fields and reset value.
`define ASHP_CFG_RESET 12'h000
`define ASHP_CFG_INT_SEL 2
`define ASHP_CFG_SCLK_SRC 3
`define ASHP_CFG_MODE_LSB 5
`define ASHP_CFG_MODE_MSB 6
`define ASHP_MODE_EOC 2'h0
// Command nibbles.
`define ASHP_CMD_SW_PDN 4'h8
`define ASHP_CMD_CFG_READ 4'h9
`define ASHP_CMD_CFG_WRITE 4'hA
`define ASHP_CMD_TEST_LO 4'hB
`define ASHP_CMD_TEST_HI 4'hD
`define ASHP_CMD_BUF_READ 4'hE
`define ASHP_CMD_RESERVED 4'hF
// Frame and timing counts.
`define ASHP_FRAME_BITS 5'h10
`define ASHP_CMD_BITS 5'h04
`define ASHP_SAMPLE_TICKS 8'h0C
`define ASHP_CONV_TICKS 8'h0E
`define ASHP_OSC_DIV 8'h02
`endif

// ### ashp_pkg.sv
// Purpose: Types of the serial host port.
// Assumes: Nothing.
// Notes: Constants live in ashp_map.svh.
`default_nettype none
package ashp_pkg;
    // Converter sequencing states.
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_SAMPLE,
        CONV_RUN
    } ashp_conv_state_t;
endpackage
`default_nettype wire

// ### ashp_top.sv
// Purpose: Serial host port and conversion sequencer of a multi-channel converter.
// Assumes: Link pins are asynchronous; I_ADC_RESULT is valid on the system clock.
// Notes: Registers are reached over APB with one wait state.
`default_nettype none
`include "ashp_map.svh"

module ashp_top #(
    parameter logic [7:0] SAMPLE_TICKS = `ASHP_SAMPLE_TICKS,
    parameter logic [7:0] CONV_TICKS = `ASHP_CONV_TICKS,
    parameter logic [7:0] OSC_DIV = `ASHP_OSC_DIV
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_SCLK,
    input wire logic I_SELECT_B,
    input wire logic I_FRAME_SYNC,
    input wire logic I_SERIAL_IN,
    output logic O_SERIAL_OUT,
    output logic O_SERIAL_OUT_OE,
    output logic O_CONV_DONE_N,
    input wire logic I_POWER_DOWN_N,
    input wire logic I_SAMPLE_START_N,
    input wire logic [11:0] I_ADC_RESULT,
    output logic [3:0] O_MUX_SEL,
    output logic O_ANALOG_ON,
    output logic O_SAMPLING
);

    initial begin
        if (SAMPLE_TICKS == 8'h00 || CONV_TICKS == 8'h00 || OSC_DIV == 8'h00) begin
            $error("ashp_top: tick counts must be at least one");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers.

    logic rst_meta;
    logic rst_n;

    // Reset is asserted at once and released through two flip-flops.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Pin order: sclk, select, frame sync, serial in, power down, sample start.
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic [5:0] pin_prev;

    // Every pin passes two flip-flops; a third stage gives the previous level.
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 6'h3E;
            pin_sync <= 6'h3E;
            pin_prev <= 6'h3E;
        end else begin
            pin_meta <= {I_SAMPLE_START_N, I_POWER_DOWN_N, I_SERIAL_IN,
                         I_FRAME_SYNC, I_SELECT_B, I_SCLK};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    logic sclk_rise, sclk_fall, sel_fall, sel_rise, fs_fall, fs_rise;
    logic serial_in, power_down_n_n, start_fall, start_rise, selected;

    // Edge detection looks only at synchronised levels.
    assign sclk_rise = pin_sync[0] & ~pin_prev[0];
    assign sclk_fall = ~pin_sync[0] & pin_prev[0];
    assign sel_fall = ~pin_sync[1] & pin_prev[1];
    assign sel_rise = pin_sync[1] & ~pin_prev[1];
    assign selected = ~pin_sync[1];
    assign fs_fall = ~pin_sync[2] & pin_prev[2];
    assign fs_rise = pin_sync[2] & ~pin_prev[2];
    assign serial_in = pin_sync[3];
    assign power_down_n_n = pin_sync[4];
    assign start_fall = ~pin_sync[5] & pin_prev[5];
    assign start_rise = pin_sync[5] & ~pin_prev[5];

    ////////////////////////////////////////////////////////////////////////////////
    // Serial frame engine.

    logic [11:0] config_word;
    logic [11:0] result;
    logic four_chan;
    logic fs_mode;
    logic in_en;
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    logic [15:0] out_shift;
    logic frame_done;
    logic int_sel;
    logic conv_done;
    logic shift_edge;
    logic [4:0] next_cnt;
    logic [15:0] next_in;

    assign int_sel = config_word[`ASHP_CFG_INT_SEL];
    // Frame sync mode samples on falling edges, plain mode on rising edges.
    assign shift_edge = selected & in_en & (fs_mode ? sclk_fall : sclk_rise);
    assign next_cnt = bit_cnt + 5'h01;
    assign next_in = {shift_in[14:0], serial_in};

    // Counter, input enable and output shifter follow select and frame sync.
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            fs_mode <= 1'b0;
            in_en <= 1'b0;
            bit_cnt <= 5'h00;
            shift_in <= 16'h0000;
            out_shift <= 16'h0000;
            O_SERIAL_OUT_OE <= 1'b0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (sel_rise) begin
                in_en <= 1'b0;
                O_SERIAL_OUT_OE <= 1'b0;
            end else if (sel_fall) begin
                bit_cnt <= 5'h00;
                fs_mode <= ~pin_sync[2];
                in_en <= pin_sync[2];
                out_shift <= {result, 4'h0};
                O_SERIAL_OUT_OE <= 1'b1;
            end else if (selected && fs_fall) begin
                bit_cnt <= 5'h00;
                fs_mode <= 1'b1;
                in_en <= 1'b1;
                out_shift <= {result, 4'h0};
                O_SERIAL_OUT_OE <= 1'b1;
            end else begin
                if (shift_edge) begin
                    shift_in <= next_in;
                    bit_cnt <= next_cnt;
                    if (next_cnt == `ASHP_CMD_BITS && next_in[3:0] == `ASHP_CMD_CFG_READ) begin
                        out_shift <= {config_word, 4'h0};
                    end else begin
                        out_shift <= {out_shift[14:0], 1'b0};
                    end
                    if (next_cnt == `ASHP_FRAME_BITS) begin
                        in_en <= 1'b0;
                        O_SERIAL_OUT_OE <= 1'b0;
                        frame_done <= 1'b1;
                    end
                end
                // An interrupt releases the output unless select or frame sync falls in the same cycle, and never costs an input edge.
                if (conv_done && int_sel) begin
                    O_SERIAL_OUT_OE <= 1'b0;
                end
            end
        end
    end

    // Serial data bit is registered from the head of the shifter.
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_SERIAL_OUT <= 1'b0;
        end else begin
            O_SERIAL_OUT <= out_shift[15];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode, done only for complete frames.

    logic [3:0] cmd;
    logic [3:0] last_cmd;
    logic cmd_start;
    logic cmd_pdn;

    assign cmd = shift_in[15:12];

    // Returns one when the command selects an input or test voltage on this variant.
    function automatic logic cmd_selects(input logic [3:0] c, input logic four);
        if (c < `ASHP_CMD_SW_PDN) begin
            cmd_selects = ~(four & c[0]);
        end else begin
            cmd_selects = (c >= `ASHP_CMD_TEST_LO) && (c <= `ASHP_CMD_TEST_HI);
        end
    endfunction

    assign cmd_start = frame_done & cmd_selects(cmd, four_chan);
    assign cmd_pdn = frame_done & (cmd == `ASHP_CMD_SW_PDN);

    // Configuration write, channel routing and last command tracking.
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            config_word <= `ASHP_CFG_RESET;
            O_MUX_SEL <= 4'h0;
            last_cmd <= 4'h0;
        end else if (frame_done && cmd != `ASHP_CMD_RESERVED) begin
            last_cmd <= cmd;
            if (cmd == `ASHP_CMD_CFG_WRITE) begin
                config_word <= shift_in[11:0];
            end
            if (cmd_selects(cmd, four_chan)) begin
                O_MUX_SEL <= cmd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power control.

    // Pin or command powers down; select or sample start restarts once the pin is high.
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_ANALOG_ON <= 1'b1;
        end else if (!power_down_n_n || cmd_pdn) begin
            O_ANALOG_ON <= 1'b0;
        end else if (sel_fall || start_fall) begin
            O_ANALOG_ON <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion clock and sequencer.

    logic [7:0] osc_cnt;
    logic osc_tick;
    logic conv_tick;

    // Internal oscillator is a divider giving a one-cycle tick.
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt <= 8'h00;
            osc_tick <= 1'b0;
        end else if (osc_cnt == OSC_DIV - 8'h01) begin
            osc_cnt <= 8'h00;
            osc_tick <= 1'b1;
        end else begin
            osc_cnt <= osc_cnt + 8'h01;
            osc_tick <= 1'b0;
        end
    end

    assign conv_tick = config_word[`ASHP_CFG_SCLK_SRC] ? sclk_rise : osc_tick;

    ashp_pkg::ashp_conv_state_t state;
    logic ext_sample;
    logic [7:0] tick_cnt;

    // Sampling is timed by sample start or by a fixed count, then conversion runs.
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ashp_pkg::CONV_IDLE;
            ext_sample <= 1'b0;
            tick_cnt <= 8'h00;
            conv_done <= 1'b0;
            result <= 12'h000;
        end else begin
            conv_done <= 1'b0;
            // Idle while powered down; the start that restarts the analog also begins sampling.
            if (!power_down_n_n || cmd_pdn || !(O_ANALOG_ON || sel_fall || start_fall)) begin
                state <= ashp_pkg::CONV_IDLE;
            end else begin
                unique case (state)
                    ashp_pkg::CONV_IDLE: begin
                        tick_cnt <= 8'h00;
                        if (start_fall) begin
                            ext_sample <= 1'b1;
                            state <= ashp_pkg::CONV_SAMPLE;
                        end else if (cmd_start) begin
                            ext_sample <= 1'b0;
                            state <= ashp_pkg::CONV_SAMPLE;
                        end
                    end
                    ashp_pkg::CONV_SAMPLE: begin
                        if (ext_sample ? start_rise : (tick_cnt == SAMPLE_TICKS - 8'h01)) begin
                            tick_cnt <= 8'h00;
                            state <= ashp_pkg::CONV_RUN;
                        end else if (!ext_sample) begin
                            tick_cnt <= tick_cnt + 8'h01;
                        end
                    end
                    ashp_pkg::CONV_RUN: begin
                        if (conv_tick) begin
                            if (tick_cnt == CONV_TICKS - 8'h01) begin
                                result <= I_ADC_RESULT;
                                conv_done <= 1'b1;
                                state <= ashp_pkg::CONV_IDLE;
                            end else begin
                                tick_cnt <= tick_cnt + 8'h01;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Sampling indicator for the analog sampler.
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_SAMPLING <= 1'b0;
        end else begin
            O_SAMPLING <= (state == ashp_pkg::CONV_SAMPLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Done or interrupt pin.

    logic int_pend;
    logic eoc_mode;

    assign eoc_mode = (config_word[`ASHP_CFG_MODE_MSB:`ASHP_CFG_MODE_LSB] == `ASHP_MODE_EOC);

    // A completion in the clearing cycle wins over the clear.
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            int_pend <= 1'b0;
        end else if (conv_done && int_sel) begin
            int_pend <= 1'b1;
        end else if (sel_fall || fs_rise) begin
            int_pend <= 1'b0;
        end
    end

    // Pin shows the interrupt, or the conversion window in mode 00 only.
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_CONV_DONE_N <= 1'b1;
        end else if (int_sel) begin
            O_CONV_DONE_N <= ~(int_pend | conv_done);
        end else begin
            O_CONV_DONE_N <= ~(eoc_mode && state == ashp_pkg::CONV_RUN && !conv_done);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave with one wait state.

    logic apb_access;
    logic apb_hit;

    assign apb_access = I_PSEL & I_PENABLE & ~O_PREADY;
    assign apb_hit = (I_PADDR == `ASHP_OFS_CTRL) || (I_PADDR == `ASHP_OFS_CONFIG) ||
                     (I_PADDR == `ASHP_OFS_STATUS) || (I_PADDR == `ASHP_OFS_RESULT);

    // Ready, read data and error are registered one cycle into the access phase.
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h00000000;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY <= apb_access;
            O_PSLVERR <= apb_access & ~apb_hit;
            O_PRDATA <= 32'h00000000;
            if (apb_access && !I_PWRITE) begin
                unique case (I_PADDR)
                    `ASHP_OFS_CTRL: O_PRDATA <= {31'h00000000, four_chan};
                    `ASHP_OFS_CONFIG: O_PRDATA <= {20'h00000, config_word};
                    `ASHP_OFS_STATUS: O_PRDATA <= {24'h000000, last_cmd, int_pend,
                                                   state == ashp_pkg::CONV_RUN,
                                                   state == ashp_pkg::CONV_SAMPLE, O_ANALOG_ON};
                    `ASHP_OFS_RESULT: O_PRDATA <= {20'h00000, result};
                    default: O_PRDATA <= 32'h00000000;
                endcase
            end
        end
    end

    // Control write takes effect at the edge where ready is sampled high.
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            four_chan <= `ASHP_CTRL_RESET;
        end else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == `ASHP_OFS_CTRL) begin
            four_chan <= I_PWDATA[`ASHP_CTRL_FOUR_CHAN];
        end
    end

endmodule // ashp_top
`default_nettype wire

// ### ashp_props.sv
// Purpose: Pin-level checks of the serial host port.
// Assumes: Bound to ashp_top; windows allow for the two-stage input synchronisers.
// Notes: All checks run on the system clock.
`default_nettype none
module ashp_chk (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_SELECT_B,
    input wire logic I_FRAME_SYNC,
    input wire logic I_POWER_DOWN_N,
    input wire logic I_SAMPLE_START_N,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic O_SERIAL_OUT_OE,
    input wire logic O_CONV_DONE_N,
    input wire logic O_ANALOG_ON,
    input wire logic O_SAMPLING
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);
    // Bus answers after one wait state; an error comes only with ready and no data.
    AST_APB_WAIT: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
        else $error("bus answer late");
    AST_APB_ERR: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
        else $error("bus error without ready");
    // Output enable follows select, frame sync, the frame end and the done pin.
    AST_IDLE_HIZ: assert property (I_SELECT_B [*6] |-> !O_SERIAL_OUT_OE)
        else $error("output driven while deselected");
    AST_SEL_RISE: assert property ($rose(I_SELECT_B) |-> ##[1:6] !O_SERIAL_OUT_OE)
        else $error("output not released at select rise");
    AST_SEL_FALL: assert property (
        $fell(I_SELECT_B) && I_FRAME_SYNC |-> ##[2:6] O_SERIAL_OUT_OE)
        else $error("output not driven after select fall");
    AST_FS_WAIT: assert property (
        $fell(I_SELECT_B) && !I_FRAME_SYNC |-> ##[2:6] O_SERIAL_OUT_OE)
        else $error("output not driven in frame sync mode");
    AST_FS_FALL: assert property (
        $fell(I_FRAME_SYNC) && !I_SELECT_B |-> ##[2:6] O_SERIAL_OUT_OE)
        else $error("output not driven after frame sync fall");
    AST_OE_END: assert property ($rose(O_SERIAL_OUT_OE) |-> ##[1:160] !O_SERIAL_OUT_OE)
        else $error("output held past the frame");
    AST_INT_HIZ: assert property ($fell(O_CONV_DONE_N) |-> ##[0:1] !O_SERIAL_OUT_OE)
        else $error("output driven after done fall");
    // Converter sequencing against its pins.
    AST_DONE_AFTER_SAMPLE: assert property ($fell(O_CONV_DONE_N) |-> !O_SAMPLING)
        else $error("done fell while sampling");
    AST_PDN: assert property (!I_POWER_DOWN_N [*6] |-> !O_ANALOG_ON)
        else $error("analog on during power down");
    AST_START_SAMPLE: assert property (
        $fell(I_SAMPLE_START_N) && I_SELECT_B |-> ##[2:6] O_SAMPLING)
        else $error("sampling not started");
    AST_START_HOLD: assert property (
        $rose(I_SAMPLE_START_N) && O_SAMPLING |-> ##[2:6] !O_SAMPLING)
        else $error("sampling not ended");
    CVR_DONE: cover property ($fell(O_CONV_DONE_N));
    CVR_FS_FRAME: cover property ($rose(O_SERIAL_OUT_OE) && !I_FRAME_SYNC);
    CVR_ERR: cover property (O_PSLVERR);
endmodule // ashp_chk
bind ashp_top ashp_chk u_chk (.I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_SELECT_B(I_SELECT_B), .I_FRAME_SYNC(I_FRAME_SYNC),
    .I_POWER_DOWN_N(I_POWER_DOWN_N), .I_SAMPLE_START_N(I_SAMPLE_START_N), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_SERIAL_OUT_OE(O_SERIAL_OUT_OE),
    .O_CONV_DONE_N(O_CONV_DONE_N), .O_ANALOG_ON(O_ANALOG_ON), .O_SAMPLING(O_SAMPLING));
`default_nettype wire

// ### ashp_host_model.sv
// Purpose: Host serial port that frames words into the converter port.
// Assumes: Link clock half period of four system clocks.
// Notes: Serial clock stands still between frames.
`default_nettype none
module ashp_host_model (
    input wire logic i_clk,
    input wire logic i_serial_out,
    input wire logic i_serial_out_oe,
    output logic o_sclk,
    output logic o_select_b,
    output logic o_frame_sync,
    output logic o_serial_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle pins: clock parked low, select and frame sync high.
    initial begin
        o_sclk = 1'h0;
        o_select_b = 1'h1;
        o_frame_sync = 1'h1;
        o_serial_in = 1'h0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Selection with the clock parked, then eight system clocks of settling.
    task automatic set_select(input logic v);
        o_select_b <= v;
        hold(8);
    endtask
    // One frame, frame sync mode when fs is set, cut after n active edges.
    task automatic frame(input logic fs, input logic [15:0] w, input int n,
                         output logic [15:0] got, output logic oe_first, output logic oe_end);
        logic act;
        act = !fs;
        got = 16'h0000;
        o_frame_sync <= !fs;
        hold(4);
        o_select_b <= 1'h0;
        hold(4);
        if (fs) begin
            o_frame_sync <= 1'h1;
            hold(4);
            o_frame_sync <= 1'h0;
            hold(4);
        end
        // Data change on the passive edge; output is read just before each active edge.
        for (int i = 0; i < n; i++) begin
            o_sclk <= !act;
            o_serial_in <= w[15 - i];
            hold(4);
            got[15 - i] = i_serial_out;
            if (i == 0) begin
                oe_first = i_serial_out_oe;
            end
            o_sclk <= act;
            hold(4);
        end
        o_sclk <= 1'h0;
        o_serial_in <= !o_serial_in;
        hold(8);
        oe_end = i_serial_out_oe;
        o_select_b <= 1'h1;
        o_frame_sync <= 1'h1;
        hold(8);
    endtask
endmodule // ashp_host_model
`default_nettype wire

// ### adc_serial_host_port_tb.sv
// Purpose: Self-checking bench of the serial host port.
// Assumes: Host model drives the link; bench drives bus and converter pins.
// Notes: Frames and bus calls run strictly one after another.
`default_nettype none
module adc_serial_host_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst_b, psel, penable, pwrite, pready, pslverr, err, oe1, oe2;
    logic sclk, sel_b, fs, serial_in, serial_out, sdo_oe, done_n, pdn_n, start_n, analog_on, sampling;
    logic [11:0] paddr, adc;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] got;
    logic [3:0] mux;
    int errors = 0;
    int n_checks = 0;
    // System clock of 40 ns.
    always #20 clk = ~clk;
    ashp_top dut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCLK(sclk), .I_SELECT_B(sel_b),
        .I_FRAME_SYNC(fs), .I_SERIAL_IN(serial_in), .O_SERIAL_OUT(serial_out), .O_SERIAL_OUT_OE(sdo_oe),
        .O_CONV_DONE_N(done_n), .I_POWER_DOWN_N(pdn_n), .I_SAMPLE_START_N(start_n),
        .I_ADC_RESULT(adc), .O_MUX_SEL(mux), .O_ANALOG_ON(analog_on), .O_SAMPLING(sampling));
    ashp_host_model host (.i_clk(clk), .i_serial_out(serial_out), .i_serial_out_oe(sdo_oe),
        .o_sclk(sclk), .o_select_b(sel_b), .o_frame_sync(fs), .o_serial_in(serial_in));
    task automatic tally_and_finish();
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask
    // One bus transfer; request held until ready is seen at an edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (k >= 50) begin
            errors++;
            $display("MISMATCH %0t bus answer timed out", $time);
            tally_and_finish();
        end
    endtask
    // Bounded wait for the done pin to reach a level.
    task automatic wait_done(input logic v);
        int k;
        k = 0;
        while (done_n !== v && k < 800) begin
            @(posedge clk);
            k++;
        end
        chk(32'(done_n), 32'(v));
        if (k >= 800) begin
            tally_and_finish();
        end
    endtask
    // Main sequence.
    initial begin
        rst_b = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pdn_n = 1'h1;
        start_n = 1'h1;
        adc = 12'hABC;
        repeat (12) @(posedge clk);
        rst_b <= 1'h1;
        repeat (4) @(posedge clk);
        apb(1'h0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 12'h010, 32'h0);
        chk(32'(err), 32'h1);
        host.frame(1'h1, 16'hA800, 16, got, oe1, oe2);
        apb(1'h0, 12'h004, 32'h0);
        chk(rd, 32'h800);
        host.frame(1'h0, 16'h9000, 16, got, oe1, oe2);
        chk(32'(got[11:0]), 32'h800);
        chk(32'({oe1, oe2}), 32'h2);
        host.frame(1'h0, 16'h2000, 16, got, oe1, oe2);
        chk(32'(mux), 32'h2);
        wait_done(1'h0);
        wait_done(1'h1);
        apb(1'h0, 12'h00C, 32'h0);
        chk(rd, 32'hABC);
        host.frame(1'h1, 16'hE000, 16, got, oe1, oe2);
        chk(32'(got), 32'hABC0);
        host.frame(1'h0, 16'hF000, 16, got, oe1, oe2);
        chk(32'(mux), 32'h2);
        apb(1'h1, 12'h000, 32'h1);
        host.frame(1'h0, 16'h3000, 16, got, oe1, oe2);
        chk(32'(mux), 32'h2);
        apb(1'h1, 12'h000, 32'h0);
        host.frame(1'h0, 16'hA0FF, 8, got, oe1, oe2);
        apb(1'h0, 12'h004, 32'h0);
        chk(rd, 32'h800);
        host.frame(1'h1, 16'hA004, 16, got, oe1, oe2);
        adc <= 12'h5A5;
        host.frame(1'h0, 16'hB000, 16, got, oe1, oe2);
        chk(32'(mux), 32'hB);
        wait_done(1'h0);
        host.frame(1'h0, 16'hE000, 16, got, oe1, oe2);
        chk(32'(done_n), 32'h1);
        chk(32'(got), 32'h5A50);
        // Held selection: a completion in interrupt mode must release the output.
        host.set_select(1'h0);
        chk(32'(sdo_oe), 32'h1);
        start_n <= 1'h0;
        repeat (8) @(posedge clk);
        start_n <= 1'h1;
        wait_done(1'h0);
        chk(32'(sdo_oe), 32'h0);
        host.set_select(1'h1);
        host.set_select(1'h0);
        chk(32'(done_n), 32'h1);
        host.set_select(1'h1);
        pdn_n <= 1'h0;
        repeat (8) @(posedge clk);
        chk(32'(analog_on), 32'h0);
        pdn_n <= 1'h1;
        repeat (4) @(posedge clk);
        start_n <= 1'h0;
        repeat (8) @(posedge clk);
        chk(32'({analog_on, sampling}), 32'h3);
        start_n <= 1'h1;
        wait_done(1'h0);
        // Link clock as conversion clock: conversion stalls while the link clock stands still.
        host.frame(1'h0, 16'hA008, 16, got, oe1, oe2);
        start_n <= 1'h0;
        repeat (8) @(posedge clk);
        start_n <= 1'h1;
        repeat (80) @(posedge clk);
        chk(32'(done_n), 32'h0);
        host.frame(1'h0, 16'hE000, 16, got, oe1, oe2);
        chk(32'(done_n), 32'h1);
        tally_and_finish();
    end
endmodule // adc_serial_host_port_tb
`default_nettype wire
